// ===== ppm_defs.vh
// Purpose: constants for the port pin mode mux
// Assumes: AXI4-Lite, 32-bit data, word-aligned registers
// Notes: offsets are byte addresses
`ifndef PPM_DEFS_VH
`define PPM_DEFS_VH
`define PPM_OFF_P0_OUT 8'h00
`define PPM_OFF_P0_DIR 8'h04
`define PPM_OFF_P0_PU 8'h08
`define PPM_OFF_P0_CTL 8'h0C
`define PPM_OFF_P0_IN 8'h10
`define PPM_OFF_P1_OUT 8'h14
`define PPM_OFF_P1_DIR 8'h18
`define PPM_OFF_P1_PU 8'h1C
`define PPM_OFF_P1_CTL 8'h20
`define PPM_OFF_P1_IN 8'h24
`define PPM_OFF_P2_CTL 8'h28
`define PPM_OFF_P2_IN 8'h2C
`define PPM_OFF_P3_OUT 8'h30
`define PPM_OFF_P3_DIR 8'h34
`define PPM_OFF_P3_PU 8'h38
`define PPM_OFF_P3_CTL 8'h3C
`define PPM_OFF_P3_IN 8'h40
`define PPM_OFF_P12 8'h44
`define PPM_OFF_P13_OUT 8'h48
`define PPM_OFF_EDGE_RISE 8'h4C
`define PPM_OFF_EDGE_FALL 8'h50
`define PPM_OFF_IRQ_STAT 8'h54
`define PPM_OFF_IRQ_MASK 8'h58
`define PPM_OFF_MEM_SIZE 8'h5C
`define PPM_MEM_SIZE_RST 8'hCF
`define PPM_DIR_RST 8'hFF
`define PPM_RESP_OKAY 2'b00
`define PPM_RESP_SLVERR 2'b10
`endif

// ===== ppm_edge_det.v
// Purpose: programmable edge detector for one external interrupt input
// Assumes: input already synchronous to aclk
// Notes: one-cycle pulse on a selected edge
`timescale 1ns/100ps
module ppm_edge_det (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // control
  input wire enable,
  input wire rise_en,
  input wire fall_en,
  // signal
  input wire sig_in,
  output reg edge_pulse
);
  reg prev_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      prev_r <= sig_in;
      edge_pulse <= enable & ((rise_en & sig_in & ~prev_r) | (fall_en & ~sig_in & prev_r)); // [R9]
    end
  end
endmodule

// ===== ppm_port_bit.v
// Purpose: one bidirectional pin: port or control mode, direction, pull-up
// Assumes: control-mode peripheral supplies its own drive and enable
// Notes: output enable high while the pin is driven
`timescale 1ns/100ps
module ppm_port_bit (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // configuration
  input wire ctl_mode,
  input wire dir_in,
  input wire pu_en,
  input wire latch_val,
  // peripheral side
  input wire alt_out,
  input wire alt_oe,
  // pin side
  input wire pin_i,
  output reg pin_o,
  output reg pin_oe,
  output reg pin_pu
);
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
      pin_pu <= 1'b0;
    end else begin
      pin_o <= ctl_mode ? alt_out : latch_val; // [R16]
      pin_oe <= ctl_mode ? alt_oe : ~dir_in; // [R8]
      pin_pu <= pu_en & (ctl_mode ? ~alt_oe : dir_in); // [R5]
    end
  end
endmodule

// ===== ppm_top.v
// Purpose: general-purpose ports with per-pin port/control mode mux
// Assumes: pins synchronous to aclk; AXI4-Lite register access
// Notes: alternate functions are routed to peripheral-side ports
// Behaviour
// [R1] port 0: four pins, per-pin direction
// [R2] port 1: eight pins, per-pin direction
// [R3] port 3: four pins, per-pin direction
// [R4] port 12: one pin, selectable direction
// [R5] pull-up enable per bidirectional port bit
// [R6] port 2 input only, analog in control
// [R7] port 13 single output only pin
// [R8] port or control mode chosen per pin
// [R9] interrupt edge: rising, falling or both
// [R10] timer input one: count clock, both captures
// [R11] timer input two: capture A only
// [R12] port 1 carries serial and UART lines
// [R13] reset is active low
// [R14] programmer drives mode pins; ground normally
// [R15] memory size resets fixed, software rewrites
// [R16] control mode routes pins to peripherals
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`include "ppm_defs.vh"
module ppm_top (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // port 0 pins
  input wire [3:0] port0_i,
  output wire [3:0] port0_o,
  output wire [3:0] port0_oe,
  output wire [3:0] port0_pu,
  // port 1 pins
  input wire [7:0] port1_i,
  output wire [7:0] port1_o,
  output wire [7:0] port1_oe,
  output wire [7:0] port1_pu,
  // port 2 pins
  input wire [3:0] port2_i,
  // port 3 pins
  input wire [3:0] port3_i,
  output wire [3:0] port3_o,
  output wire [3:0] port3_oe,
  output wire [3:0] port3_pu,
  // port 12 pin
  input wire port12_i,
  output wire port12_o,
  output wire port12_oe,
  output wire port12_pu,
  // port 13 pin
  output reg port13_o,
  // programming mode pins
  input wire prog_mode_pin_a,
  output reg prog_mode_active,
  // timer 16 side
  output reg timer16_count_capture_in,
  output reg timer16_capture_a_trig,
  output reg timer16_capture_b_trig,
  input wire timer16_out,
  // timer 8 and timer h side
  output reg timer8_count_in,
  input wire timer8_out,
  input wire timer_h_a_out,
  input wire timer_h_b_out,
  // clocked serial side
  output reg csi_serial_in,
  input wire csi_serial_out,
  output reg csi_serial_clock_in,
  input wire csi_serial_clock_out,
  input wire csi_serial_clock_oe,
  // uart side
  output reg uart_a_receive,
  input wire uart_a_transmit,
  input wire uart_a_select,
  output reg uart_b_receive,
  input wire uart_b_transmit,
  // analog side
  output reg [3:0] analog_inputs,
  // external interrupt events, memory size select and interrupt
  output reg [5:0] ext_irq_pulse,
  output reg [7:0] memory_size_select,
  output reg irq
);
  reg [3:0] p0_out_r, port0_direction, port0_pullup_enable, p0_ctl_r;
  reg [7:0] p1_out_r, port1_direction, port1_pullup_enable, p1_ctl_r;
  reg [3:0] p2_ctl_r;
  reg [3:0] p3_out_r, port3_direction, port3_pullup_enable, p3_ctl_r;
  reg p12_out_r, port12_direction, port12_pullup_enable, p12_ctl_r;
  reg [5:0] edge_rise_r, edge_fall_r, irq_stat_r, irq_mask_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg aw_have_r, w_have_r;
  reg [31:0] rd_nxt;
  reg rd_ok;
  reg p13_out_nxt_r;
  wire p13_out_nxt;
  wire [5:0] edge_ev;
  wire [5:0] irq_src;
  wire wr_go;
  wire rd_go;
  wire [7:0] p1_alt_o;
  wire [7:0] p1_alt_oe;
  wire [5:0] irq_ctl;
  genvar g;

  // alternate outputs of port 1: bit0 clock/uart a tx, 2 csi out, 3 uart b tx,
  // 5 timer h a, 6 timer h b, 7 timer 8; 6 and 7 drive only when set as output
  assign p1_alt_o = {timer8_out, timer_h_b_out, timer_h_a_out, 1'b0, uart_b_transmit,
                     csi_serial_out, 1'b0,
                     uart_a_select ? uart_a_transmit : csi_serial_clock_out}; // [R12]
  assign p1_alt_oe = {~port1_direction[7], ~port1_direction[6], 1'b1, 1'b0, 1'b1, 1'b1, 1'b0,
                      uart_a_select | csi_serial_clock_oe}; // [R12]

  generate
    for (g = 0; g < 4; g = g + 1) begin : gp0
      ppm_port_bit u_bit (
        .aclk(aclk), .aresetn(aresetn),
        .ctl_mode(p0_ctl_r[g]), .dir_in(port0_direction[g]),
        .pu_en(port0_pullup_enable[g]), .latch_val(p0_out_r[g]),
        .alt_out(timer16_out), .alt_oe((g == 1) & ~port0_direction[g]),
        .pin_i(port0_i[g]), .pin_o(port0_o[g]), .pin_oe(port0_oe[g]),
        .pin_pu(port0_pu[g])
      ); // [R1]
    end
    for (g = 0; g < 8; g = g + 1) begin : gp1
      ppm_port_bit u_bit (
        .aclk(aclk), .aresetn(aresetn),
        .ctl_mode(p1_ctl_r[g]), .dir_in(port1_direction[g]),
        .pu_en(port1_pullup_enable[g]), .latch_val(p1_out_r[g]),
        .alt_out(p1_alt_o[g]), .alt_oe(p1_alt_oe[g]),
        .pin_i(port1_i[g]), .pin_o(port1_o[g]), .pin_oe(port1_oe[g]),
        .pin_pu(port1_pu[g])
      ); // [R2]
    end
    for (g = 0; g < 4; g = g + 1) begin : gp3
      ppm_port_bit u_bit (
        .aclk(aclk), .aresetn(aresetn),
        .ctl_mode(p3_ctl_r[g]), .dir_in(port3_direction[g]),
        .pu_en(port3_pullup_enable[g]), .latch_val(p3_out_r[g]),
        .alt_out(1'b0), .alt_oe(1'b0),
        .pin_i(port3_i[g]), .pin_o(port3_o[g]), .pin_oe(port3_oe[g]),
        .pin_pu(port3_pu[g])
      ); // [R3]
    end
  endgenerate

  ppm_port_bit u_p12 (
    .aclk(aclk), .aresetn(aresetn),
    .ctl_mode(p12_ctl_r), .dir_in(port12_direction),
    .pu_en(port12_pullup_enable), .latch_val(p12_out_r),
    .alt_out(1'b0), .alt_oe(1'b0),
    .pin_i(port12_i), .pin_o(port12_o), .pin_oe(port12_oe),
    .pin_pu(port12_pu)
  ); // [R4]

  // interrupt sources: 0 port12, 1..4 port3, 5 port1 bit6
  assign irq_src = {port1_i[6], port3_i, port12_i};
  assign irq_ctl = {p1_ctl_r[6], p3_ctl_r, p12_ctl_r};
  generate
    for (g = 0; g < 6; g = g + 1) begin : gedge
      ppm_edge_det u_edge (
        .aclk(aclk), .aresetn(aresetn),
        .enable(irq_ctl[g]), .rise_en(edge_rise_r[g]), .fall_en(edge_fall_r[g]),
        .sig_in(irq_src[g]), .edge_pulse(edge_ev[g])
      ); // [R9]
    end
  endgenerate

  // peripheral inputs, valid only when the pin is in control mode
  always @(posedge aclk) begin
    if (!aresetn) begin // [R13]
      timer16_count_capture_in <= 1'b0;
      timer16_capture_a_trig <= 1'b0;
      timer16_capture_b_trig <= 1'b0;
      timer8_count_in <= 1'b0;
      csi_serial_in <= 1'b0;
      csi_serial_clock_in <= 1'b0;
      uart_a_receive <= 1'b1;
      uart_b_receive <= 1'b1;
      analog_inputs <= 4'h0;
      ext_irq_pulse <= 6'h00;
      prog_mode_active <= 1'b0;
      port13_o <= 1'b0;
    end else begin
      timer16_count_capture_in <= p0_ctl_r[0] & port0_i[0]; // [R10]
      timer16_capture_b_trig <= p0_ctl_r[0] & port0_i[0]; // [R10]
      timer16_capture_a_trig <= (p0_ctl_r[0] & port0_i[0]) |
                                (p0_ctl_r[1] & port0_i[1]); // [R11]
      timer8_count_in <= p1_ctl_r[7] & port1_i[7];
      csi_serial_in <= p1_ctl_r[1] & port1_i[1]; // [R12]
      csi_serial_clock_in <= p1_ctl_r[0] & port1_i[0]; // [R12]
      uart_a_receive <= ~p1_ctl_r[1] | port1_i[1]; // [R12]
      uart_b_receive <= ~p1_ctl_r[4] | port1_i[4]; // [R12]
      analog_inputs <= p2_ctl_r & port2_i; // [R6]
      ext_irq_pulse <= edge_ev;
      prog_mode_active <= prog_mode_pin_a; // [R14]
      port13_o <= p13_out_nxt; // [R7]
    end
  end

  assign p13_out_nxt = p13_out_nxt_r;

  // axi write path: address and data accepted in either order
  assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign rd_go = s_axi_arvalid & s_axi_arready;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PPM_RESP_OKAY;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      p0_out_r <= 4'h0; port0_direction <= 4'hF; port0_pullup_enable <= 4'h0; p0_ctl_r <= 4'h0;
      p1_out_r <= 8'h00; port1_direction <= `PPM_DIR_RST; port1_pullup_enable <= 8'h00;
      p1_ctl_r <= 8'h00;
      p2_ctl_r <= 4'h0;
      p3_out_r <= 4'h0; port3_direction <= 4'hF; port3_pullup_enable <= 4'h0; p3_ctl_r <= 4'h0;
      p12_out_r <= 1'b0; port12_direction <= 1'b1; port12_pullup_enable <= 1'b0;
      p12_ctl_r <= 1'b0;
      p13_out_nxt_r <= 1'b0;
      edge_rise_r <= 6'h00;
      edge_fall_r <= 6'h00;
      irq_mask_r <= 6'h00;
      memory_size_select <= `PPM_MEM_SIZE_RST; // [R15]
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr;
        aw_have_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_have_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `PPM_RESP_OKAY;
        case (aw_addr_r)
          `PPM_OFF_P0_OUT: p0_out_r <= w_data_r[3:0];
          `PPM_OFF_P0_DIR: port0_direction <= w_data_r[3:0]; // [R1]
          `PPM_OFF_P0_PU: port0_pullup_enable <= w_data_r[3:0]; // [R5]
          `PPM_OFF_P0_CTL: p0_ctl_r <= w_data_r[3:0]; // [R8]
          `PPM_OFF_P1_OUT: p1_out_r <= w_data_r[7:0];
          `PPM_OFF_P1_DIR: port1_direction <= w_data_r[7:0]; // [R2]
          `PPM_OFF_P1_PU: port1_pullup_enable <= w_data_r[7:0]; // [R5]
          `PPM_OFF_P1_CTL: p1_ctl_r <= w_data_r[7:0]; // [R8]
          `PPM_OFF_P2_CTL: p2_ctl_r <= w_data_r[3:0]; // [R6]
          `PPM_OFF_P3_OUT: p3_out_r <= w_data_r[3:0];
          `PPM_OFF_P3_DIR: port3_direction <= w_data_r[3:0]; // [R3]
          `PPM_OFF_P3_PU: port3_pullup_enable <= w_data_r[3:0]; // [R5]
          `PPM_OFF_P3_CTL: p3_ctl_r <= w_data_r[3:0]; // [R8]
          `PPM_OFF_P12: begin
            p12_out_r <= w_data_r[0];
            port12_direction <= w_data_r[1]; // [R4]
            port12_pullup_enable <= w_data_r[2]; // [R5]
            p12_ctl_r <= w_data_r[3];
          end
          `PPM_OFF_P13_OUT: p13_out_nxt_r <= w_data_r[0]; // [R7]
          `PPM_OFF_EDGE_RISE: edge_rise_r <= w_data_r[5:0];
          `PPM_OFF_EDGE_FALL: edge_fall_r <= w_data_r[5:0];
          `PPM_OFF_IRQ_MASK: irq_mask_r <= w_data_r[5:0];
          `PPM_OFF_MEM_SIZE: memory_size_select <= w_data_r[7:0]; // [R15]
          `PPM_OFF_P0_IN, `PPM_OFF_P1_IN, `PPM_OFF_P2_IN, `PPM_OFF_P3_IN,
          `PPM_OFF_IRQ_STAT: s_axi_bresp <= `PPM_RESP_OKAY;
          default: s_axi_bresp <= `PPM_RESP_SLVERR;
        endcase
      end
    end
  end

  // read decode; port read path shows 0 for pins in control mode
  always @* begin
    rd_ok = 1'b1;
    rd_nxt = 32'h0000_0000;
    case (s_axi_araddr)
      `PPM_OFF_P0_OUT: rd_nxt[3:0] = p0_out_r;
      `PPM_OFF_P0_DIR: rd_nxt[3:0] = port0_direction;
      `PPM_OFF_P0_PU: rd_nxt[3:0] = port0_pullup_enable;
      `PPM_OFF_P0_CTL: rd_nxt[3:0] = p0_ctl_r;
      `PPM_OFF_P0_IN: rd_nxt[3:0] = port0_i & ~p0_ctl_r; // [R16]
      `PPM_OFF_P1_OUT: rd_nxt[7:0] = p1_out_r;
      `PPM_OFF_P1_DIR: rd_nxt[7:0] = port1_direction;
      `PPM_OFF_P1_PU: rd_nxt[7:0] = port1_pullup_enable;
      `PPM_OFF_P1_CTL: rd_nxt[7:0] = p1_ctl_r;
      `PPM_OFF_P1_IN: rd_nxt[7:0] = port1_i & ~p1_ctl_r; // [R16]
      `PPM_OFF_P2_CTL: rd_nxt[3:0] = p2_ctl_r;
      `PPM_OFF_P2_IN: rd_nxt[3:0] = port2_i & ~p2_ctl_r; // [R6]
      `PPM_OFF_P3_OUT: rd_nxt[3:0] = p3_out_r;
      `PPM_OFF_P3_DIR: rd_nxt[3:0] = port3_direction;
      `PPM_OFF_P3_PU: rd_nxt[3:0] = port3_pullup_enable;
      `PPM_OFF_P3_CTL: rd_nxt[3:0] = p3_ctl_r;
      `PPM_OFF_P3_IN: rd_nxt[3:0] = port3_i & ~p3_ctl_r; // [R16]
      `PPM_OFF_P12: rd_nxt[4:0] = {port12_i & ~p12_ctl_r, p12_ctl_r,
                                   port12_pullup_enable, port12_direction, p12_out_r};
      `PPM_OFF_P13_OUT: rd_nxt[0] = p13_out_nxt_r;
      `PPM_OFF_EDGE_RISE: rd_nxt[5:0] = edge_rise_r;
      `PPM_OFF_EDGE_FALL: rd_nxt[5:0] = edge_fall_r;
      `PPM_OFF_IRQ_STAT: rd_nxt[5:0] = irq_stat_r;
      `PPM_OFF_IRQ_MASK: rd_nxt[5:0] = irq_mask_r;
      `PPM_OFF_MEM_SIZE: rd_nxt[7:0] = memory_size_select;
      default: rd_ok = 1'b0;
    endcase
  end

  // read channel, sticky status cleared by read, new event wins
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PPM_RESP_OKAY;
      irq_stat_r <= 6'h00;
      irq <= 1'b0;
    end else begin
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_nxt;
        s_axi_rresp <= rd_ok ? `PPM_RESP_OKAY : `PPM_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      if (rd_go && s_axi_araddr == `PPM_OFF_IRQ_STAT)
        irq_stat_r <= edge_ev;
      else
        irq_stat_r <= irq_stat_r | edge_ev;
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end
endmodule

// ===== ppm_pin_env.sv
// Purpose: outside circuitry on the bidirectional pins of one port
// Assumes: one instance per port, level resolved every cycle
// Notes: an undriven pin without pull-up shows the inverse of its last level
`timescale 1ns/100ps
module ppm_pin_env #(
  parameter W = 4
) (
  // clock
  input logic aclk,
  // device side
  input logic [W-1:0] o,
  input logic [W-1:0] oe,
  input logic [W-1:0] pu,
  // outside drivers
  input logic [W-1:0] drv,
  input logic [W-1:0] drv_en,
  // resolved level
  output logic [W-1:0] lvl
);
  logic [W-1:0] last_r = '0;
  always @(posedge aclk) begin
    last_r <= lvl;
  end
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe[i]) begin
        lvl[i] = o[i];
      end else if (drv_en[i]) begin
        lvl[i] = drv[i];
      end else if (pu[i]) begin
        lvl[i] = 1'b1;
      end else begin
        lvl[i] = ~last_r[i];
      end
    end
  end
endmodule

// ===== ppm_checker.sv
// Purpose: port-level assertions for ppm_top
// Assumes: sees the top-level ports only
// Notes: bound into ppm_top below
`timescale 1ns/100ps
module ppm_checker (
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // pins
  input logic [3:0] port0_i,
  input logic [3:0] port0_oe,
  input logic [7:0] port1_oe,
  input logic [7:0] port1_pu,
  input logic [3:0] port2_i,
  input logic [3:0] port3_i,
  input logic [3:0] port3_oe,
  input logic [3:0] port3_pu,
  input logic port12_oe,
  input logic port12_pu,
  input logic prog_mode_pin_a,
  // peripheral side
  input logic prog_mode_active,
  input logic timer16_count_capture_in,
  input logic timer16_capture_a_trig,
  input logic timer16_capture_b_trig,
  input logic [3:0] analog_inputs,
  input logic [5:0] ext_irq_pulse,
  input logic [7:0] memory_size_select,
  input logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence p3_toggled;
    $past(port3_i[0], 2) != $past(port3_i[0], 3);
  endsequence
  chk_reset_state: assert property (
    $rose(aresetn) |-> port0_oe == 4'h0 && port1_oe == 8'h00 && !irq
      && memory_size_select == 8'hCF) else $error("outputs not at reset state");
  chk_pullup_input: assert property (
    (port1_pu & port1_oe) == 8'h00 && (port3_pu & port3_oe) == 4'h0)
    else $error("pull-up on a driven pin");
  chk_p12_pullup: assert property (!(port12_pu && port12_oe))
    else $error("port 12 pull-up while driven");
  chk_analog_src: assert property ((analog_inputs & ~$past(port2_i)) == 4'h0)
    else $error("analog input high without pin");
  chk_edge_pulse: assert property (ext_irq_pulse[1] |-> p3_toggled)
    else $error("interrupt pulse without pin edge");
  chk_capture_pair: assert property (
    timer16_count_capture_in == timer16_capture_b_trig) else $error("count and capture differ");
  chk_capture_b_src: assert property (timer16_capture_b_trig |-> $past(port0_i[0]))
    else $error("capture b without first timer pin");
  chk_capture_a_src: assert property (
    timer16_capture_a_trig |-> $past(port0_i[0]) || $past(port0_i[1]))
    else $error("capture a without timer pin");
  chk_prog_copy: assert property (1'b1 |=> prog_mode_active == $past(prog_mode_pin_a))
    else $error("programming mode copy wrong");
endmodule
bind ppm_top ppm_checker i_ppm_checker (.*);

// ===== ppm_top_test.sv
// Purpose: self-checking bench for ppm_top
// Assumes: AXI4-Lite master tasks, pin partners per port
// Notes: expectations follow the register map constants
`timescale 1ns/100ps
`include "ppm_defs.vh"
module ppm_top_test;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire awready, wready, bvalid, arready, rvalid, irq, p13_o, t16c, t16a, t16b, ua_rx, ub_rx;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] p0_o, p0_oe, p0_pu, p0_lvl, p3_o, p3_oe, p3_pu, p3_lvl, ana;
  wire [7:0] p1_o, p1_oe, p1_pu, p1_lvl, msel;
  wire p12_o, p12_oe, p12_pu, p12_lvl;
  wire pm_act, t8_in, csi_in, csi_ck;
  wire [5:0] xirq;
  logic [2:0][7:0] drv = 24'h000000;
  logic [2:0][7:0] den = 24'h0FFF0F;
  logic [3:0] p2_in = 0;
  logic [9:0] periph = 10'h201;
  logic pmode = 0, p12_drv = 0, p12_den = 0;
  int failures = 0, check_count = 0, cyc = 0;
  localparam logic [2:0][7:0] msk = 24'h0FFF0F;
  localparam logic [2:0][7:0] base = {`PPM_OFF_P3_OUT, `PPM_OFF_P1_OUT, `PPM_OFF_P0_OUT};
  wire [2:0][7:0] oe_v = {4'h0, p3_oe, p1_oe, 4'h0, p0_oe};
  wire [2:0][7:0] o_v = {4'h0, p3_o, p1_o, 4'h0, p0_o};
  wire [2:0][7:0] pu_v = {4'h0, p3_pu, p1_pu, 4'h0, p0_pu};
  always #2.5 aclk = ~aclk;
  ppm_top i_ppm_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port0_i(p0_lvl), .port0_o(p0_o), .port0_oe(p0_oe), .port0_pu(p0_pu),
    .port1_i(p1_lvl), .port1_o(p1_o), .port1_oe(p1_oe), .port1_pu(p1_pu),
    .port2_i(p2_in), .port3_i(p3_lvl), .port3_o(p3_o), .port3_oe(p3_oe), .port3_pu(p3_pu),
    .port12_i(p12_lvl), .port12_o(p12_o), .port12_oe(p12_oe), .port12_pu(p12_pu),
    .port13_o(p13_o), .prog_mode_pin_a(pmode), .prog_mode_active(pm_act),
    .timer16_count_capture_in(t16c), .timer16_capture_a_trig(t16a),
    .timer16_capture_b_trig(t16b), .timer16_out(periph[0]),
    .timer8_count_in(t8_in), .timer8_out(periph[1]), .timer_h_a_out(periph[2]),
    .timer_h_b_out(periph[3]), .csi_serial_in(csi_in), .csi_serial_out(periph[4]),
    .csi_serial_clock_in(csi_ck), .csi_serial_clock_out(periph[5]),
    .csi_serial_clock_oe(periph[6]),
    .uart_a_receive(ua_rx), .uart_a_transmit(periph[7]), .uart_a_select(periph[8]),
    .uart_b_receive(ub_rx), .uart_b_transmit(periph[9]), .analog_inputs(ana),
    .ext_irq_pulse(xirq), .memory_size_select(msel), .irq(irq)
  );
  ppm_pin_env #(.W(4)) i_ppm_pin_env0 (.aclk(aclk), .o(p0_o), .oe(p0_oe), .pu(p0_pu),
    .drv(drv[0][3:0]), .drv_en(den[0][3:0]), .lvl(p0_lvl));
  ppm_pin_env #(.W(8)) i_ppm_pin_env1 (.aclk(aclk), .o(p1_o), .oe(p1_oe), .pu(p1_pu),
    .drv(drv[1]), .drv_en(den[1]), .lvl(p1_lvl));
  ppm_pin_env #(.W(4)) i_ppm_pin_env3 (.aclk(aclk), .o(p3_o), .oe(p3_oe), .pu(p3_pu),
    .drv(drv[2][3:0]), .drv_en(den[2][3:0]), .lvl(p3_lvl));
  ppm_pin_env #(.W(1)) i_ppm_pin_env12 (.aclk(aclk), .o(p12_o), .oe(p12_oe), .pu(p12_pu),
    .drv(p12_drv), .drv_en(p12_den), .lvl(p12_lvl));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk(bresp, `PPM_RESP_OKAY);
    repeat (2) @(posedge aclk);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic results;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  initial begin
    logic [7:0] pat;
    logic [31:0] d;
    logic [1:0] r;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk(oe_v[0] | oe_v[1] | oe_v[2], 8'h00);
    chk(p12_oe, 1'b0);
    axr(`PPM_OFF_MEM_SIZE, d, r);
    chk(d, 32'h000000CF);
    axw(`PPM_OFF_MEM_SIZE, 32'h00000042);
    chk(msel, 8'h42);
    pmode <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(pm_act, 1'b1);
    pmode <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      pat = 8'hA5 & msk[k];
      den[k] <= ~pat & msk[k];
      drv[k] <= 8'h5A;
      axw(base[k] + 8'h04, {24'h0, ~pat & msk[k]});
      axw(base[k], 32'h0000003C);
      axw(base[k] + 8'h08, {24'h0, msk[k]});
      chk(oe_v[k], pat);
      chk(o_v[k] & pat, 8'h3C & pat);
      chk(pu_v[k], ~pat & msk[k]);
      axr(base[k] + 8'h10, d, r);
      chk(d, {24'h0, (8'h3C & pat) | (8'h5A & ~pat & msk[k])});
      axw(base[k] + 8'h04, {24'h0, msk[k]});
      axw(base[k] + 8'h08, 32'h0);
      den[k] <= msk[k];
    end
    axw(`PPM_OFF_P12, 32'h00000001);
    chk({p12_oe, p12_o}, 2'b11);
    axw(`PPM_OFF_P12, 32'h00000006);
    chk({p12_oe, p12_pu}, 2'b01);
    axr(`PPM_OFF_P12, d, r);
    chk(d[4], 1'b1);
    p12_den <= 1'b1;
    axr(`PPM_OFF_P12, d, r);
    chk(d[4], 1'b0);
    axw(`PPM_OFF_P13_OUT, 32'h00000001);
    chk(p13_o, 1'b1);
    p2_in <= 4'hF;
    axw(`PPM_OFF_P2_CTL, 32'h00000005);
    chk(ana, 4'h5);
    drv[0] <= 8'h01;
    axw(`PPM_OFF_P0_CTL, 32'h00000001);
    chk({t16c, t16a, t16b}, 3'b111);
    drv[0] <= 8'h02;
    axw(`PPM_OFF_P0_CTL, 32'h00000002);
    chk({t16c, t16a, t16b}, 3'b010);
    axw(`PPM_OFF_P0_DIR, 32'h0000000D);
    chk({p0_oe[1], p0_o[1]}, 2'b11);
    den[1] <= 8'h10;
    drv[1] <= 8'h00;
    axw(`PPM_OFF_P1_CTL, 32'h00000018);
    chk({p1_oe[3], p1_o[3], ub_rx}, 3'b110);
    chk(ua_rx, 1'b1);
    den[1] <= 8'h83;
    drv[1] <= 8'h82;
    axw(`PPM_OFF_P1_CTL, 32'h00000083);
    chk({csi_ck, csi_in, t8_in, ua_rx, p1_oe[0]}, 5'b01110);
    periph[8:7] <= 2'b11;
    axw(`PPM_OFF_P1_DIR, 32'h0000007F);
    chk({p1_oe[7], p1_o[7], p1_oe[0], p1_o[0]}, 4'b1011);
    drv[2] <= 8'h00;
    axw(`PPM_OFF_P3_CTL, 32'h00000001);
    axw(`PPM_OFF_IRQ_MASK, 32'h00000002);
    for (int k = 1; k < 4; k++) begin
      axw(`PPM_OFF_EDGE_RISE, {30'h0, k[0], 1'b0});
      axw(`PPM_OFF_EDGE_FALL, {30'h0, k[1], 1'b0});
      axr(`PPM_OFF_IRQ_STAT, d, r);
      drv[2] <= 8'h01;
      repeat (6) @(posedge aclk);
      chk(irq, k[0]);
      axr(`PPM_OFF_IRQ_STAT, d, r);
      chk(d, {30'h0, k[0], 1'b0});
      drv[2] <= 8'h00;
      repeat (6) @(posedge aclk);
      chk(irq, k[1]);
      axr(`PPM_OFF_IRQ_STAT, d, r);
      chk(d, {30'h0, k[1], 1'b0});
    end
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    axw(`PPM_OFF_IRQ_MASK, 32'h0);
    drv[2] <= 8'h01;
    repeat (3) @(posedge aclk);
    chk(xirq, 6'h02);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    axr(`PPM_OFF_IRQ_STAT, d, r);
    chk(d, 32'h00000002);
    axr(8'h80, d, r);
    chk({r, d}, {`PPM_RESP_SLVERR, 32'h0});
    results();
  end
endmodule
